/* hdl/dsdp_cal_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dsdp_cal_if;
    logic [5:0] cal_code;
    logic fb_early;
    modport loop(output cal_code, input fb_early);
    modport user(input cal_code, output fb_early);
endinterface
`default_nettype wire

/* hdl/dsdp_cal_loop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsdp_cfg.svh"
module dsdp_cal_loop (
    input wire logic clk,
    input wire logic rst_n,
    dsdp_cal_if.loop cal
);
    logic [5:0] code_ff;
    // Code steps each system clock toward feedback balance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= `DSDP_CAL_MID;
        end else if (cal.fb_early && code_ff != `DSDP_CAL_MAX) begin
            code_ff <= code_ff + 6'h01;
        end else if (!cal.fb_early && code_ff != `DSDP_CAL_MIN) begin
            code_ff <= code_ff - 6'h01;
        end
    end
    assign cal.cal_code = code_ff;
endmodule
`default_nettype wire

/* hdl/dsdp_cfg.svh */
`ifndef DSDP_CFG_SVH
`define DSDP_CFG_SVH
`define DSDP_CAL_W 6
`define DSDP_GROUP_LR 16
`define DSDP_GROUP_TB 18
`define DSDP_CAL_MID 6'h20
`define DSDP_CAL_MAX 6'h3f
`define DSDP_CAL_MIN 6'h00
`endif

/* hdl/dsdp_pkg.sv */
package dsdp_pkg;
    typedef logic [5:0] dsdp_cal_t;
    typedef enum logic [1:0] {
        DSDP_IDLE = 2'b00,
        DSDP_PRE = 2'b01,
        DSDP_BURST = 2'b11
    } dsdp_state_e;
endpackage

/* hdl/dsdp_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsdp_cfg.svh"
module dsdp_top #(
    parameter int DATA_W = `DSDP_GROUP_LR,
    parameter int DELAY_MAX = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe_in,
    input wire logic strobe_oe_n,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic edge_clock_one,
    input wire logic fb_early_a,
    input wire logic fb_early_b,
    input wire logic half_sel,
    output logic strobe_delay_cell,
    output logic [5:0] cal_code_a,
    output logic [5:0] cal_code_b,
    output logic sync_clock_polarity,
    output logic preamble_seen,
    output logic [DATA_W-1:0] rise_data,
    output logic [DATA_W-1:0] fall_data,
    output logic rd_valid,
    output logic [DATA_W-1:0] write_transfer_strobe,
    output logic quarter_phase_delay
);
    dsdp_cal_if cal_a();
    dsdp_cal_if cal_b();
    assign cal_a.fb_early = fb_early_a;
    assign cal_b.fb_early = fb_early_b;
    dsdp_cal_loop u_loop_a (.clk(clk), .rst_n(rst_n), .cal(cal_a));
    dsdp_cal_loop u_loop_b (.clk(clk), .rst_n(rst_n), .cal(cal_b));
    assign cal_code_a = cal_a.cal_code;
    assign cal_code_b = cal_b.cal_code;

    // Three-stage samplers for link inputs
    logic [2:0] stb_s_ff, oe_s_ff, ec_s_ff;
    logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_s_ff <= 3'h7;
            oe_s_ff <= 3'h7;
            ec_s_ff <= 3'h0;
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
            dq_s3_ff <= '0;
        end else begin
            stb_s_ff <= {stb_s_ff[1:0], strobe_in};
            oe_s_ff <= {oe_s_ff[1:0], strobe_oe_n};
            ec_s_ff <= {ec_s_ff[1:0], edge_clock_one};
            dq_s1_ff <= dq_in;
            dq_s2_ff <= dq_s1_ff;
            dq_s3_ff <= dq_s2_ff;
        end
    end
    logic stb_rise, stb_fall, ec_rise, term_to_low;
    assign stb_rise = stb_s_ff[1] && !stb_s_ff[2];
    assign stb_fall = !stb_s_ff[1] && stb_s_ff[2];
    assign ec_rise = ec_s_ff[1] && !ec_s_ff[2];
    // Released strobe counts as terminated high
    // Memory drives the pin low from termination: oe_n must be low in the same sample as the strobe fall
    assign term_to_low = stb_fall && oe_s_ff[1] == 1'b0;

    // Delay tap from the code of this group's half
    logic [5:0] tap;
    assign tap = half_sel ? cal_b.cal_code : cal_a.cal_code;
    logic [DELAY_MAX-1:0] stb_line_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_line_ff <= '1;
        end else begin
            stb_line_ff <= {stb_line_ff[DELAY_MAX-2:0], stb_s_ff[2]};
        end
    end
    logic del_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            del_ff <= 1'b1;
        end else begin
            del_ff <= stb_line_ff[tap];
        end
    end
    assign strobe_delay_cell = del_ff;

    // Preamble detector and polarity hold
    dsdp_pkg::dsdp_state_e st_ff;
    logic pol_ff, pre_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= dsdp_pkg::DSDP_IDLE;
        end else begin
            case (st_ff)
                dsdp_pkg::DSDP_IDLE: begin
                    if (term_to_low) begin
                        st_ff <= dsdp_pkg::DSDP_PRE;
                    end
                end
                dsdp_pkg::DSDP_PRE: begin
                    if (stb_rise) begin
                        st_ff <= dsdp_pkg::DSDP_BURST;
                    end else if (oe_s_ff[2]) begin
                        st_ff <= dsdp_pkg::DSDP_IDLE;
                    end
                end
                dsdp_pkg::DSDP_BURST: begin
                    if (oe_s_ff[2]) begin
                        st_ff <= dsdp_pkg::DSDP_IDLE;
                    end
                end
                default: st_ff <= dsdp_pkg::DSDP_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pol_ff <= 1'b0;
            pre_ff <= 1'b0;
        end else begin
            pre_ff <= term_to_low && st_ff == dsdp_pkg::DSDP_IDLE;
            if (term_to_low && st_ff == dsdp_pkg::DSDP_IDLE) begin
                // Pick the edge away from the strobe phase
                pol_ff <= ec_s_ff[2];
            end
        end
    end
    assign sync_clock_polarity = pol_ff;
    assign preamble_seen = pre_ff;

    // Double-rate capture, moved out on edge clock one rise when polarity is 1, else on the next clock
    logic [DATA_W-1:0] rise_cap_ff, fall_cap_ff, rise_ff, fall_ff;
    logic have_r_ff, vld_ff, xfer;
    assign xfer = have_r_ff && (pol_ff ? ec_rise : 1'b1);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_cap_ff <= '0;
            fall_cap_ff <= '0;
            have_r_ff <= 1'b0;
        end else if (st_ff == dsdp_pkg::DSDP_BURST || stb_rise) begin
            if (stb_rise) begin
                rise_cap_ff <= dq_s3_ff;
            end
            if (stb_fall && st_ff == dsdp_pkg::DSDP_BURST) begin
                fall_cap_ff <= dq_s3_ff;
                have_r_ff <= 1'b1;
            end else if (xfer) begin
                have_r_ff <= 1'b0;
            end
        end else begin
            have_r_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_ff <= '0;
            fall_ff <= '0;
            vld_ff <= 1'b0;
        end else begin
            vld_ff <= xfer;
            if (xfer) begin
                rise_ff <= rise_cap_ff;
                fall_ff <= fall_cap_ff;
            end
        end
    end
    assign rise_data = rise_ff;
    assign fall_data = fall_ff;
    assign rd_valid = vld_ff;

    // Quarter shift of edge clock one through the calibrated line
    logic [DELAY_MAX-1:0] ec_line_ff;
    logic qp_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ec_line_ff <= '0;
            qp_ff <= 1'b0;
        end else begin
            ec_line_ff <= {ec_line_ff[DELAY_MAX-2:0], ec_s_ff[2]};
            qp_ff <= ec_line_ff[tap >> 2];
        end
    end
    assign quarter_phase_delay = qp_ff;
    assign write_transfer_strobe = {DATA_W{qp_ff}};
    // Group widths fixed by DATA_W parameter per edge
endmodule
`default_nettype wire

/* test/dsdp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsdp_mem_model #(parameter int DATA_W = 16) (
    input wire logic go,
    input wire logic stray,
    input wire logic [DATA_W-1:0] rw,
    input wire logic [DATA_W-1:0] fw,
    output logic strobe,
    output logic oe_n,
    output logic [DATA_W-1:0] dq,
    output logic done
);
    initial begin
        strobe = 1'b1;
        oe_n = 1'b1;
        dq = '0;
        done = 1'b0;
    end
    always @(posedge go) begin
        done = 1'b0;
        oe_n = 1'b0;
        strobe = 1'b0; // Preamble low from terminated level
        #160;
        repeat (2) begin
            #40 dq = rw;
            #40 strobe = 1'b1;
            #40 dq = fw;
            #40 strobe = 1'b0;
        end
        #40 dq = ~fw;
        oe_n = 1'b1;
        strobe = 1'b1; // Released to termination
        done = 1'b1;
    end
    always @(posedge stray) begin
        strobe = 1'b0;
        #80 strobe = 1'b1;
    end
endmodule
`default_nettype wire

/* test/dsdp_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dsdp_top_asserts #(parameter int DATA_W = 16) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic strobe_oe_n,
    input wire logic fb_early_a,
    input wire logic fb_early_b,
    input wire logic [5:0] cal_code_a,
    input wire logic [5:0] cal_code_b,
    input wire logic sync_clock_polarity,
    input wire logic preamble_seen,
    input wire logic [DATA_W-1:0] rise_data,
    input wire logic rd_valid,
    input wire logic [DATA_W-1:0] write_transfer_strobe,
    input wire logic quarter_phase_delay
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_pulse; preamble_seen |=> !preamble_seen; endproperty
    a_pulse: assert property (p_pulse) else $error("long preamble pulse");
    property p_pre_oe; preamble_seen |-> $past(!strobe_oe_n, 2); endproperty
    a_pre_oe: assert property (p_pre_oe) else $error("preamble while undriven");
    property p_hold; !preamble_seen |-> $stable(sync_clock_polarity); endproperty
    a_hold: assert property (p_hold) else $error("polarity moved");
    property p_wts; rst_n |-> write_transfer_strobe == {DATA_W{quarter_phase_delay}}; endproperty
    a_wts: assert property (p_wts) else $error("strobe span");
    property p_inc; fb_early_a[*3] ##0 cal_code_a != 6'h3f |=> cal_code_a == $past(cal_code_a) + 6'h01; endproperty
    a_inc: assert property (p_inc) else $error("code a no step");
    property p_dec; (!fb_early_b)[*3] ##0 cal_code_b != 6'h00 |=> cal_code_b == $past(cal_code_b) - 6'h01; endproperty
    a_dec: assert property (p_dec) else $error("code b no step");
    property p_sat; cal_code_a == 6'h3f && fb_early_a |=> cal_code_a == 6'h3f; endproperty
    a_sat: assert property (p_sat) else $error("code a wrap");
    property p_stand; !rd_valid |-> $stable(rise_data); endproperty
    a_stand: assert property (p_stand) else $error("data moved");
endmodule
bind dsdp_top dsdp_top_asserts #(.DATA_W(DATA_W)) dsdp_top_asserts_i (.clk(clk), .rst_n(rst_n),
    .strobe_oe_n(strobe_oe_n), .fb_early_a(fb_early_a), .fb_early_b(fb_early_b),
    .cal_code_a(cal_code_a), .cal_code_b(cal_code_b), .sync_clock_polarity(sync_clock_polarity),
    .preamble_seen(preamble_seen), .rise_data(rise_data), .rd_valid(rd_valid),
    .write_transfer_strobe(write_transfer_strobe), .quarter_phase_delay(quarter_phase_delay));
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic lvl; logic hs; logic [15:0] rw; logic [15:0] fw;} dsdp_row_s;
    dsdp_row_s rows[4] = '{'{1'b0, 1'b0, 16'ha5c3, 16'h3c5a}, '{1'b1, 1'b1, 16'hffff, 16'h0000},
        '{1'b0, 1'b1, 16'h0001, 16'h8000}, '{1'b1, 1'b0, 16'h1234, 16'hedcb}};
    logic clk = 1'b0, rst_n = 1'b0, ecl = 1'b0, ec_run = 1'b0, hs = 1'b0, fa = 1'b1, fb = 1'b0;
    logic go = 1'b0, stray = 1'b0, stb, oen, done, pol, pre, rdv, sdc, qpd;
    logic [15:0] wts;
    logic [15:0] rw = 16'h0000, fw = 16'h0000, dq, rd, fd;
    logic [5:0] ca, cb;
    int failures = 0, samples_checked = 0, nv = 0, np = 0;
    always #2.5 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        #1 if (ec_run) ecl = ~ecl;
    end
    always @(posedge clk) begin
        if (rdv === 1'b1) nv++;
        if (pre === 1'b1) np++;
    end
    dsdp_top dsdp_top_i (.clk(clk), .rst_n(rst_n), .strobe_in(stb), .strobe_oe_n(oen), .dq_in(dq),
        .edge_clock_one(ecl), .fb_early_a(fa), .fb_early_b(fb), .half_sel(hs),
        .strobe_delay_cell(sdc), .cal_code_a(ca), .cal_code_b(cb), .sync_clock_polarity(pol),
        .preamble_seen(pre), .rise_data(rd), .fall_data(fd), .rd_valid(rdv),
        .write_transfer_strobe(wts), .quarter_phase_delay(qpd));
    dsdp_mem_model dsdp_mem_model_i (.go(go), .stray(stray), .rw(rw), .fw(fw), .strobe(stb),
        .oe_n(oen), .dq(dq), .done(done));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic do_read(input dsdp_row_s r);
        int k;
        @(posedge clk);
        #1 ecl = r.lvl;
        hs = r.hs;
        rw = r.rw;
        fw = r.fw;
        nv = 0;
        // Let the edge clock level settle through the samplers before the preamble
        repeat (6) @(posedge clk);
        #1 go = 1'b1;
        k = 0;
        while (pre !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1 k++;
        end
        chk({15'h0, pre}, 16'h0001);
        chk({15'h0, pol}, {15'h0, r.lvl});
        ec_run = 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1 k++;
        end
        go = 1'b0;
        repeat (40) @(posedge clk);
        #1 ec_run = 1'b0;
        chk(16'(nv), 16'h0002);
        chk(rd, r.rw);
        chk(fd, r.fw);
    endtask
    initial begin
        repeat (15) @(posedge clk);
        #1 chk({4'h0, ca, cb}, {4'h0, 6'h20, 6'h20});
        @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (rows[i]) do_read(rows[i]);
        chk({4'h0, ca, cb}, {4'h0, 6'h3f, 6'h00});
        fa = 1'b0;
        fb = 1'b1;
        np = 0;
        stray = 1'b1;
        repeat (80) @(posedge clk);
        #1 chk({4'h0, ca, cb}, {4'h0, 6'h00, 6'h3f});
        chk(16'(np), 16'h0000);
        chk({15'h0, sdc}, 16'h0001);
        chk({15'h0, qpd}, {15'h0, ecl});
        chk(wts, {16{ecl}});
        tally_and_finish();
    end
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
